// *** hw/flash_word_pkg.sv ***
// shared constants and types of the single word flash programmer
package flash_word_pkg;
  // register byte offsets (low address bits decoded)
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_KEY   = 8'h04;
  localparam logic [7:0] OFS_PTR   = 8'h08;
  localparam logic [7:0] OFS_LATCH = 8'h0C;
  localparam logic [7:0] OFS_STORE = 8'h10;
  localparam logic [7:0] OFS_HOLD  = 8'h14;
  // flash_control_reg fields
  localparam int CTRL_LAUNCH_BIT = 1;
  localparam int CTRL_PERMIT_BIT = 2;
  localparam int CTRL_REJECT_BIT = 3;
  localparam int CTRL_SPM_BIT    = 5;
  // table_store_op field
  localparam int STORE_INC_BIT = 0;
  // unlock key pair
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // widths and reset values
  localparam int         PTR_W     = 22;
  localparam int         BYTE_W    = 8;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [PTR_W-1:0]  PTR_RST   = 22'h000000;
  localparam logic [BYTE_W-1:0] LATCH_RST = 8'h00;
  localparam logic [BYTE_W-1:0] HOLD_RST  = 8'hFF;
  // word_program_time: value arbitrary, no figure available
  localparam int CLK_MHZ           = 25;
  localparam int WORD_PROG_TIME_US = 1000;
  localparam int WORD_PROG_CYCLES  = WORD_PROG_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_ONE  = 2'b01,
    KEY_TWO  = 2'b11
  } key_state_t;
endpackage

// *** hw/prog_if.sv ***
// handshake between the sequencer and its program timer
`timescale 1ns/10ps
`default_nettype none
interface prog_if;
  logic start;
  logic busy;
  logic done;
  modport ctl (output start, input busy, input done);
  modport tmr (input start, output busy, output done);
endinterface
`default_nettype wire

// *** hw/prog_timer.sv ***
// word program timer: holds busy for a fixed number of cycles
`timescale 1ns/10ps
`default_nettype none
module prog_timer #(
  parameter int CYCLES = flash_word_pkg::WORD_PROG_CYCLES
) (
  input  wire logic clk,   // core clock
  input  wire logic rst,   // synchronous reset
  prog_if.tmr       pi     // start in, busy and done out
);
  logic        busy_q;
  logic        done_q;
  logic [31:0] cnt_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      cnt_q  <= 32'h0000_0000;
    end else if (pi.start && !busy_q) begin
      busy_q <= 1'b1;
      cnt_q  <= 32'(CYCLES - 1);
    end else if (busy_q && cnt_q == 32'h0000_0000) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q && cnt_q == 32'h0000_0000;
    end
  end

  assign pi.busy = busy_q;
  assign pi.done = done_q;

  ////////////////////////////////////////////////////////////////////////////
  timer_start_a: assert property (@(posedge clk) disable iff (rst) // [R10]
    pi.start && !busy_q |=> busy_q)
    else $error("timer did not start");

  done_pulse_a: assert property (@(posedge clk) disable iff (rst) // [R10]
    $fell(busy_q) |-> pi.done)
    else $error("no done pulse at end of program time");
endmodule
`default_nettype wire

// *** hw/flash_word_prog.sv ***
// single word flash program sequencer with an ahb-lite register port
// What this block and its software do
// R1 - Launch needs program-permit and single-pair-mode; it writes two bytes.
// R2 - Software targets only erased words; no erase is done here.
// R3 - Software loads the table pointer with an even word address first.
// R4 - A table store copies the latch into the byte picked by pointer bit 0.
// R5 - Store one gives the low byte with post-increment, store two the high.
// R6 - The second store leaves the table pointer where it is.
// R7 - At launch the pointer is on the high byte and gives the word address.
// R8 - A launch not directly after key writes 55h then AAh is rejected.
// R9 - Setting the launch bit after a good key pair starts the word write.
// R10 - The core stalls for the whole program time, then is released.
// R11 - Software masks interrupts around the key pair and launch.
// R12 - Software clears single-pair-mode and program-permit after the write.
`timescale 1ns/10ps
`default_nettype none
module flash_word_prog #(
  parameter int PROG_CYCLES = flash_word_pkg::WORD_PROG_CYCLES
) (
  input  wire logic        CORE_CLK,    // core clock, 25 MHz
  input  wire logic        RST,         // synchronous reset, high
  input  wire logic        HSEL,        // ahb slave select
  input  wire logic [31:0] HADDR,       // ahb address
  input  wire logic [1:0]  HTRANS,      // ahb transfer type
  input  wire logic        HWRITE,      // ahb write
  input  wire logic [2:0]  HSIZE,       // ahb size
  input  wire logic [31:0] HWDATA,      // ahb write data
  input  wire logic        HREADY,      // ahb ready in
  output var  logic        HREADYOUT,   // ahb ready out
  output var  logic        HRESP,       // ahb response, always okay
  output var  logic [31:0] HRDATA,      // ahb read data
  output var  logic        CPU_STALL,   // core stall during programming
  output var  logic        FLASH_PROG,  // array program strobe, level
  output var  logic [flash_word_pkg::PTR_W-2:0] FLASH_ADDR, // word address
  output var  logic [15:0] FLASH_DATA   // word to program
);
  localparam int PW = flash_word_pkg::PTR_W;
  localparam int BW = flash_word_pkg::BYTE_W;

  prog_if pi ();

  prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .clk (CORE_CLK),
    .rst (RST),
    .pi  (pi.tmr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus data phase
  logic       dp_valid_q;
  logic       dp_write_q;
  logic [7:0] dp_addr_q;
  logic       wr;
  logic       sel_ctrl;
  logic       sel_key;
  logic       sel_ptr;
  logic       sel_latch;
  logic       sel_store;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q  <= 8'h00;
    end else if (HREADY) begin
      dp_valid_q <= HSEL && HTRANS[1];
      dp_write_q <= HWRITE && HSIZE == flash_word_pkg::SIZE_WORD;
      dp_addr_q  <= HADDR[7:0];
    end
  end

  // any access while programming waits, so the core cannot run on
  assign HREADYOUT = !(pi.busy && dp_valid_q); // [R10]
  assign HRESP     = 1'b0;
  assign wr        = dp_valid_q && dp_write_q && HREADYOUT;
  assign sel_ctrl  = dp_addr_q == flash_word_pkg::OFS_CTRL;
  assign sel_key   = dp_addr_q == flash_word_pkg::OFS_KEY;
  assign sel_ptr   = dp_addr_q == flash_word_pkg::OFS_PTR;
  assign sel_latch = dp_addr_q == flash_word_pkg::OFS_LATCH;
  assign sel_store = dp_addr_q == flash_word_pkg::OFS_STORE;

  ////////////////////////////////////////////////////////////////////////////
  // unlock key pair
  flash_word_pkg::key_state_t key_q;
  flash_word_pkg::key_state_t key_d;

  always_comb begin
    key_d = flash_word_pkg::KEY_IDLE;
    if (!wr) begin
      key_d = key_q;
    end else if (sel_key) begin
      case (key_q)
        flash_word_pkg::KEY_ONE: begin
          if (HWDATA[7:0] == flash_word_pkg::KEY_SECOND) begin
            key_d = flash_word_pkg::KEY_TWO; // [R8]
          end else if (HWDATA[7:0] == flash_word_pkg::KEY_FIRST) begin
            key_d = flash_word_pkg::KEY_ONE;
          end
        end
        default: begin
          if (HWDATA[7:0] == flash_word_pkg::KEY_FIRST) begin
            key_d = flash_word_pkg::KEY_ONE; // [R8]
          end
        end
      endcase
    end
  end

  // any other word-sized write, the launch included, spends the key
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      key_q <= flash_word_pkg::KEY_IDLE;
    end else begin
      key_q <= key_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control bits and launch
  logic permit_q;
  logic spm_q;
  logic reject_q;
  logic launch_req;
  logic launch_ok;

  assign launch_req = wr && sel_ctrl
                      && HWDATA[flash_word_pkg::CTRL_LAUNCH_BIT];
  assign launch_ok  = launch_req && !pi.busy
                      && HWDATA[flash_word_pkg::CTRL_PERMIT_BIT]   // [R1]
                      && HWDATA[flash_word_pkg::CTRL_SPM_BIT]      // [R1]
                      && key_q == flash_word_pkg::KEY_TWO;         // [R8]
  assign pi.start   = launch_ok; // [R9]

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      permit_q <= 1'b0;
      spm_q    <= 1'b0;
    end else if (wr && sel_ctrl) begin
      permit_q <= HWDATA[flash_word_pkg::CTRL_PERMIT_BIT];
      spm_q    <= HWDATA[flash_word_pkg::CTRL_SPM_BIT];
    end
  end

  // sticky, write one to clear; a new reject wins over the clear
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      reject_q <= 1'b0;
    end else if (launch_req && !launch_ok) begin
      reject_q <= 1'b1; // [R8]
    end else if (wr && sel_ctrl
                 && HWDATA[flash_word_pkg::CTRL_REJECT_BIT]) begin
      reject_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // table pointer, table latch and holding bytes
  logic [PW-1:0] ptr_q;
  logic [BW-1:0] latch_q;
  logic [BW-1:0] hold_q [2];

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ptr_q <= flash_word_pkg::PTR_RST;
    end else if (wr && sel_ptr) begin
      ptr_q <= HWDATA[PW-1:0];
    end else if (wr && sel_store
                 && HWDATA[flash_word_pkg::STORE_INC_BIT]) begin
      ptr_q <= ptr_q + {{(PW-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      latch_q <= flash_word_pkg::LATCH_RST;
    end else if (wr && sel_latch) begin
      latch_q <= HWDATA[BW-1:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      hold_q[0] <= flash_word_pkg::HOLD_RST;
      hold_q[1] <= flash_word_pkg::HOLD_RST;
    end else if (wr && sel_store) begin
      hold_q[ptr_q[0]] <= latch_q; // [R4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array side
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      FLASH_ADDR <= '0;
      FLASH_DATA <= 16'hFFFF;
    end else if (launch_ok) begin
      FLASH_ADDR <= ptr_q[PW-1:1]; // [R7]
      FLASH_DATA <= {hold_q[1], hold_q[0]};
    end
  end

  assign FLASH_PROG = pi.busy; // [R9]
  assign CPU_STALL  = pi.busy; // [R10]

  ////////////////////////////////////////////////////////////////////////////
  // read side
  function automatic logic [31:0] rd_word(input logic [7:0] a,
                                          input logic       bsy);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      flash_word_pkg::OFS_CTRL: begin
        r[flash_word_pkg::CTRL_LAUNCH_BIT] = bsy;
        r[flash_word_pkg::CTRL_PERMIT_BIT] = permit_q;
        r[flash_word_pkg::CTRL_REJECT_BIT] = reject_q;
        r[flash_word_pkg::CTRL_SPM_BIT]    = spm_q;
      end
      flash_word_pkg::OFS_PTR:   r[PW-1:0] = ptr_q;
      flash_word_pkg::OFS_LATCH: r[BW-1:0] = latch_q;
      flash_word_pkg::OFS_HOLD:  r[15:0]   = {hold_q[1], hold_q[0]};
      default:                   r         = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // a stalled read only completes once the write is over, so it reports
  // the launch bit as already clear
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      HRDATA <= 32'h0000_0000;
    end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      HRDATA <= rd_word(HADDR[7:0], pi.busy);
    end else if (dp_valid_q && !HREADYOUT) begin
      HRDATA <= rd_word(dp_addr_q, 1'b0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [31:0] stall_cnt_q;

  always_ff @(posedge CORE_CLK) begin
    if (RST || launch_ok) begin
      stall_cnt_q <= 32'h0000_0000;
    end else if (CPU_STALL) begin
      stall_cnt_q <= stall_cnt_q + 32'h0000_0001;
    end
  end

  launch_permit_a: assert property ( // [R1]
    @(posedge CORE_CLK) disable iff (RST)
    launch_ok |=> permit_q && spm_q && FLASH_PROG)
    else $error("write launched without permit and word mode");

  hold_store_a: assert property (@(posedge CORE_CLK) disable iff (RST) // [R4]
    wr && sel_store |=> hold_q[$past(ptr_q[0])] == $past(latch_q))
    else $error("holding byte not loaded from latch");

  target_word_a: assert property (@(posedge CORE_CLK) disable iff (RST) // [R7]
    launch_ok |=> FLASH_ADDR == $past(ptr_q[PW-1:1])
                  && FLASH_DATA == {$past(hold_q[1]), $past(hold_q[0])})
    else $error("wrong word address or data at launch");

  key_order_a: assert property (@(posedge CORE_CLK) disable iff (RST) // [R8]
    $rose(FLASH_PROG) |-> $past(key_q, 2) == flash_word_pkg::KEY_TWO
                          && key_q == flash_word_pkg::KEY_IDLE)
    else $error("write started without key pair");

  bad_launch_a: assert property (@(posedge CORE_CLK) disable iff (RST) // [R8]
    launch_req && key_q != flash_word_pkg::KEY_TWO && !pi.busy
    |=> reject_q && !FLASH_PROG ##1 !FLASH_PROG)
    else $error("unkeyed launch not rejected");

  launch_start_a: assert property ( // [R9]
    @(posedge CORE_CLK) disable iff (RST)
    launch_req && !pi.busy && key_q == flash_word_pkg::KEY_TWO
    && HWDATA[flash_word_pkg::CTRL_PERMIT_BIT]
    && HWDATA[flash_word_pkg::CTRL_SPM_BIT]
    |=> FLASH_PROG && CPU_STALL && !reject_q)
    else $error("keyed launch did not start");

  stall_len_a: assert property (@(posedge CORE_CLK) disable iff (RST) // [R10]
    $fell(CPU_STALL) |-> stall_cnt_q == 32'(PROG_CYCLES))
    else $error("stall length differs from program time");

  stall_bus_a: assert property (@(posedge CORE_CLK) disable iff (RST) // [R10]
    CPU_STALL |-> $stable(ptr_q) && $stable(latch_q) && !wr)
    else $error("register changed during stall");
endmodule
`default_nettype wire

// *** sim/flash_array_model.sv ***
// behavioural flash array on the far side of the word programmer
`timescale 1ns/10ps
`default_nettype none
module flash_array_model (
  input  wire logic        clk,      // core clock
  input  wire logic        prog,     // program strobe, level
  input  wire logic [20:0] addr,     // word address
  input  wire logic [15:0] data,     // word to program
  output var  logic        wr_evt,   // one cycle at each program start
  output var  logic [36:0] wr_info,  // {address, data} taken
  output var  logic [15:0] wr_old    // word content before programming
);
  logic [15:0] mem [int];
  logic        prog_q;
  logic [15:0] cur;

  initial begin
    prog_q = 1'b0;
    wr_evt = 1'b0;
    wr_info = '0;
    wr_old = 16'hFFFF;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    prog_q <= prog;
    wr_evt <= prog && !prog_q;
    if (prog && !prog_q) begin
      // unwritten words read as erased
      cur = mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hFFFF;
      wr_old <= cur;
      // programming only clears bits, so a used word is corrupted
      mem[int'(addr)] = cur & data;
      wr_info <= {addr, data};
    end
  end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the single word flash programmer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int P = 8;
  logic        CORE_CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP;
  logic        CPU_STALL, FLASH_PROG, wr_evt, rd_pend;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [31:0] HADDR, HWDATA, HRDATA, e, ptr1;
  logic [20:0] FLASH_ADDR;
  logic [15:0] FLASH_DATA, wr_old, stall_n;
  logic [36:0] wr_info, pe;
  logic [21:0] ptr;
  logic [7:0]  lo, hi;
  logic [31:0] rq [$];
  logic [36:0] pq [$];
  int          bad_count, check_count;
  integer      seed;
  logic [7:0]  k1 [5] = '{8'h00, 8'hAA, 8'h55, 8'h55, 8'h55};
  logic [7:0]  k2 [5] = '{8'h00, 8'h55, 8'hAA, 8'hAA, 8'hAA};
  logic [7:0]  cw [5] = '{8'h2E, 8'h26, 8'h26, 8'h22, 8'h06};
  logic [7:0]  ce [5] = '{8'h2C, 8'h2C, 8'h2C, 8'h28, 8'h0C};

  flash_word_prog #(.PROG_CYCLES(P)) u_flash_word_prog (
    .CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .HRDATA(HRDATA), .CPU_STALL(CPU_STALL), .FLASH_PROG(FLASH_PROG),
    .FLASH_ADDR(FLASH_ADDR), .FLASH_DATA(FLASH_DATA));

  flash_array_model u_flash_array_model (
    .clk(CORE_CLK), .prog(FLASH_PROG), .addr(FLASH_ADDR),
    .data(FLASH_DATA), .wr_evt(wr_evt), .wr_info(wr_info),
    .wr_old(wr_old));

  always #20 CORE_CLK = ~CORE_CLK;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [63:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one transfer; each phase waits for ready, a program time may hold it low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    do @(posedge CORE_CLK); while (!HREADYOUT);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CORE_CLK); while (!HREADYOUT);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rq.push_back(x);
    bus(1'b0, a, 32'h00000000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge CORE_CLK) begin
    if (rd_pend && HREADYOUT) begin
      e = rq.size() ? rq.pop_front() : ~HRDATA;
      check("read", {32'h0, HRDATA}, {32'h0, e});
      check("resp", {63'h0, HRESP}, 64'h0);
    end
    if (RST)
      rd_pend <= 1'b0;
    else if (HREADYOUT)
      rd_pend <= HSEL && HTRANS[1] && !HWRITE;
    if (CPU_STALL)
      stall_n <= stall_n + 16'h1;
    else if (stall_n != 16'h0) begin
      check("stall", {48'h0, stall_n}, 64'(P));
      stall_n <= 16'h0;
    end
    if (wr_evt) begin
      pe = pq.size() ? pq.pop_front() : ~wr_info;
      check("word", {27'h0, wr_info}, {27'h0, pe});
      check("erased", {48'h0, wr_old}, 64'hFFFF);
    end
  end

  initial begin
    #(40 * 4000);
    bad_count++;
    results;
  end

  initial begin
    {CORE_CLK, HSEL, HWRITE, rd_pend} = 4'h0;
    RST = 1'b1;
    HTRANS = 2'h0;
    HSIZE = 3'h2;
    HADDR = 32'h0;
    HWDATA = 32'h0;
    stall_n = 16'h0;
    seed = 32'h01b45d79;
    repeat (6) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    rd(flash_word_pkg::OFS_CTRL, 32'h0);
    rd(flash_word_pkg::OFS_HOLD, 32'h0000FFFF);
    rd(flash_word_pkg::OFS_PTR, 32'h0);
    rd(8'h40, 32'h0);
    // word writes at random even targets
    repeat (3) begin
      ptr = 22'($random(seed)) & 22'h3FFFFE;
      lo = 8'($random(seed));
      hi = 8'($random(seed));
      ptr1 = {10'h0, ptr} + 32'h1;
      wr(flash_word_pkg::OFS_PTR, {10'h0, ptr});
      wr(flash_word_pkg::OFS_LATCH, {24'h0, lo});
      wr(flash_word_pkg::OFS_STORE, 32'h1);
      wr(flash_word_pkg::OFS_LATCH, {24'h0, hi});
      wr(flash_word_pkg::OFS_STORE, 32'h0);
      rd(flash_word_pkg::OFS_PTR, ptr1);
      rd(flash_word_pkg::OFS_HOLD, {16'h0, hi, lo});
      pq.push_back({ptr[21:1], hi, lo});
      wr(flash_word_pkg::OFS_KEY, 32'h55);
      wr(flash_word_pkg::OFS_KEY, 32'hAA);
      wr(flash_word_pkg::OFS_CTRL, 32'h26);
      rd(flash_word_pkg::OFS_CTRL, 32'h24);
      wr(flash_word_pkg::OFS_CTRL, 32'h0);
      rd(flash_word_pkg::OFS_CTRL, 32'h0);
    end
    // refused launches: bad key, broken key, permit or pair mode missing
    for (int i = 0; i < 5; i++) begin
      wr(flash_word_pkg::OFS_KEY, {24'h0, k1[i]});
      wr(flash_word_pkg::OFS_KEY, {24'h0, k2[i]});
      if (i == 2)
        wr(flash_word_pkg::OFS_PTR, 32'h0);
      wr(flash_word_pkg::OFS_CTRL, {24'h0, cw[i]});
      rd(flash_word_pkg::OFS_CTRL, {24'h0, ce[i]});
      wr(flash_word_pkg::OFS_CTRL, 32'h08);
      rd(flash_word_pkg::OFS_CTRL, 32'h0);
    end
    // byte-sized writes must leave the pointer alone
    HSIZE <= 3'h0;
    wr(flash_word_pkg::OFS_PTR, 32'h123);
    HSIZE <= 3'h2;
    rd(flash_word_pkg::OFS_PTR, 32'h0);
    repeat (2) @(posedge CORE_CLK);
    check("pending", 64'(rq.size() + pq.size()), 64'h0);
    results;
  end
endmodule
`default_nettype wire
